// *** logic/acs_defines.svh ***
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_NCH          8
`define ACS_DATA_W       12
`define ACS_CONV_CYCLES  10
`define ACS_TRG_OFF      3'h0
`define ACS_TRG_EVENT    3'h7
`define ACS_TOUCH_CNT    4
`define ACS_AVG_LOG_11   2
`define ACS_AVG_LOG_12   4
`define ACS_RES_8        2'h0
`define ACS_RES_10       2'h1
`define ACS_RES_11       2'h2
`define ACS_RES_12       2'h3
`define ACS_FLAG_W       6
`define ACS_F_NEW        0
`define ACS_F_OVR        1
`define ACS_F_LOW        2
`define ACS_F_HIGH       3
`define ACS_F_IN         4
`define ACS_F_READY      5

`endif

// *** logic/acs_pkg.sv ***
package acs_pkg;
	typedef struct packed {
		logic [1:0] bit_depth_select;
		logic [5:0] clock_divider_select;
		logic [6:0] warmup_cycles;
		logic [3:0] sample_hold_cycles;
		logic       power_down_idle;
	} acs_cfg_t;

	typedef struct packed {
		logic [2:0]  channel;
		logic [11:0] data;
	} acs_sample_t;

	typedef struct packed {
		logic        compare_enable;
		logic [11:0] compare_low_limit;
		logic [11:0] compare_high_limit;
	} acs_cmp_t;

	typedef enum logic [2:0] {
		ACS_IDLE, ACS_WARM, ACS_PICK, ACS_HOLD, ACS_CONV, ACS_DONE
	} acs_state_t;
endpackage

// *** logic/acs_clock_divider.sv ***
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_clock_divider
	import acs_pkg::*;
(
	input  wire logic       clk,     // Peripheral bus clock
	input  wire logic       rst,     // Synchronous reset
	input  wire logic [5:0] select,  // Division is 2*(select+1)
	output logic            tick     // One pulse per conversion clock
);
	logic [5:0] count;
	logic       phase;

	wire wrap = (count >= select);

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 6'h00;
			phase <= 1'b0;
		end else begin
			count <= wrap ? 6'h00 : count + 6'h01;
			if (wrap)
				phase <= ~phase;
		end
	end

	// One tick per full period: 2 at select 0, 128 at select 63
	assign tick = wrap & phase;
endmodule

// *** logic/acs_sequencer.sv ***
`timescale 1ns/1ps
`include "acs_defines.svh"
// Operation
// - Warm-up counted 8..1024 clocks, steps of 8
// - Cell powers up on first sequence, stays on unless power-down-when-idle
// - Power-down-when-idle forces warm-up every sequence
// - Sample-hold lasts 1..16 conversion clocks
// - Trigger runs one sequence over enabled channels
// - Set/clear strobes edit enabled channel view
// - Result stored with its channel number
// - Powered-down cell waits warm-up before converting
// - Channels converted ascending, stop when none left
// - Power down after sequence when idle mode
// - Per sample: sample-hold then ten cycles
// - Compare each result when compare enabled
// - Below, above, within flags from limits
// - Unmask/mask strobes edit interrupt mask view
// - Latched flags hold until written clear
// - Live flags are sources of latched flags
// - Trigger code seven starts on peripheral event
// - Ready bit set while sequencer idle and no trigger pending
// - Touch mode enables up to four channels from offset, none past channel 7
// - Touch sequencer takes up to four channels at offset, none past channel 7
// - Depth: 8, 10, or averaged 11/12 bits
// - Conversion clock divides bus clock 2..128
// - Overrun when unread result is overwritten
// - Start strobe pends, sequence begins on next conversion clock
module acs_sequencer
	import acs_pkg::*;
(
	input  wire logic        clk,                  // Peripheral bus clock
	input  wire logic        rst,                  // Synchronous reset
	input  wire acs_cfg_t    cfg,                  // Conversion configuration
	input  wire acs_cmp_t    cmp,                  // Window compare setup
	input  wire logic [2:0]  trigger_source_select, // Trigger mode
	input  wire logic        peripheral_event,     // Event pulse, same clock
	input  wire logic        start,                // Software start pulse
	input  wire logic [7:0]  channel_enable_set,   // Enable strobe per channel
	input  wire logic [7:0]  channel_enable_clear, // Disable strobe per channel
	input  wire logic        touch_mode_enable,    // Touch group active
	input  wire logic [2:0]  touch_pin_offset,     // First touch channel
	input  wire logic [5:0]  irq_unmask_set,       // Unmask strobes
	input  wire logic [5:0]  irq_mask_set,         // Mask strobes
	input  wire logic [5:0]  latched_flag_clear,   // Clear strobes
	input  wire logic        sample_read,          // Result read pulse
	input  wire logic [11:0] cell_result,          // Raw cell data
	output logic             cell_power,           // Analog cell powered
	output logic             cell_sample,          // Sample-and-hold active
	output logic             cell_start,           // Conversion start pulse
	output logic [2:0]       cell_channel,         // Input multiplexer select
	output logic             touch_active,         // Touch sequencer owns channel
	output logic [7:0]       channel_enable_view,  // Active channels
	output acs_sample_t      latest_sample_reg,    // Last result and channel
	output logic [5:0]       live_flags_reg,       // Instantaneous status
	output logic [5:0]       latched_flags_reg,    // Sticky status
	output logic [5:0]       irq_mask_view,        // Enabled sources
	output logic             irq                   // Interrupt request
);
	acs_state_t  state;
	logic        tick;
	logic        pending;
	logic [10:0] count;
	logic [2:0]  chan;
	logic [4:0]  rep;
	logic [15:0] acc;
	logic [7:0]  chen;
	logic        cmp_low;
	logic        cmp_high;
	logic        cmp_in;
	logic        unread;
	logic        ovr;

	acs_clock_divider u_div (
		.clk    (clk),
		.rst    (rst),
		.select (cfg.clock_divider_select),
		.tick   (tick)
	);

	// Touch group channels, wrapping above channel 7 is dropped
	logic [7:0] touch_mask;
	genvar gi;
	generate
		for (gi = 0; gi < `ACS_NCH; gi++) begin : g_touch
			wire [3:0] rel = 4'(gi) - {1'b0, touch_pin_offset};
			assign touch_mask[gi] = touch_mode_enable && (gi >= touch_pin_offset)
				&& (rel < 4'(`ACS_TOUCH_CNT));
		end
	endgenerate
	assign channel_enable_view = chen | touch_mask;

	wire trig_event = (trigger_source_select == `ACS_TRG_EVENT) & peripheral_event;
	wire trig = start | trig_event;

	// Next enabled channel at or above chan
	logic       found;
	logic [2:0] next_chan;
	always_comb begin
		found = 1'b0;
		next_chan = 3'h0;
		for (int i = `ACS_NCH - 1; i >= 0; i--) begin
			if (channel_enable_view[i] && (3'(i) >= chan)) begin
				found = 1'b1;
				next_chan = 3'(i);
			end
		end
	end

	wire [10:0] warm_len = {1'b0, cfg.warmup_cycles, 3'h0} + 11'h008;
	wire [10:0] hold_len = {7'h00, cfg.sample_hold_cycles} + 11'h001;
	wire [4:0]  reps = (cfg.bit_depth_select == `ACS_RES_12) ? 5'd16 :
		(cfg.bit_depth_select == `ACS_RES_11) ? 5'd4 : 5'd1;
	wire        last_rep = (rep + 5'd1 >= reps);
	wire        conv_end = tick && (state == ACS_CONV) && (count == 11'(`ACS_CONV_CYCLES - 1));
	wire        result_now = conv_end && last_rep;
	wire [15:0] acc_sum = acc + {6'h00, cell_result[9:0]};

	// Scale the raw code or the averaged sum to the selected depth
	logic [11:0] result;
	always_comb begin
		case (cfg.bit_depth_select)
			`ACS_RES_8:  result = {4'h0, cell_result[9:2]};
			`ACS_RES_10: result = {2'h0, cell_result[9:0]};
			`ACS_RES_11: result = {1'b0, acc_sum[11:1]};
			default:     result = acc_sum[13:2];
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ACS_IDLE;
			pending <= 1'b0;
			count <= 11'h000;
			chan <= 3'h0;
			rep <= 5'h00;
			acc <= 16'h0000;
			cell_power <= 1'b0;
		end else begin
			if (trig)
				pending <= 1'b1;
			else if (state == ACS_IDLE && tick)
				pending <= 1'b0;
			if (tick) begin
				case (state)
					ACS_IDLE: if (pending) begin
						chan <= 3'h0;
						count <= 11'h000;
						cell_power <= 1'b1;
						state <= cell_power ? ACS_PICK : ACS_WARM;
					end
					ACS_WARM: begin
						count <= count + 11'h001;
						if (count + 11'h001 >= warm_len) begin
							count <= 11'h000;
							state <= ACS_PICK;
						end
					end
					ACS_PICK: begin
						count <= 11'h000;
						rep <= 5'h00;
						acc <= 16'h0000;
						if (found) begin
							chan <= next_chan;
							state <= ACS_HOLD;
						end else
							state <= ACS_DONE;
					end
					ACS_HOLD: begin
						count <= count + 11'h001;
						if (count + 11'h001 >= hold_len) begin
							count <= 11'h000;
							state <= ACS_CONV;
						end
					end
					ACS_CONV: begin
						count <= count + 11'h001;
						if (conv_end) begin
							count <= 11'h000;
							acc <= acc_sum;
							rep <= rep + 5'd1;
							if (last_rep) begin
								state <= (chan == 3'h7) ? ACS_DONE : ACS_PICK;
								chan <= chan + 3'h1;
							end else
								state <= ACS_HOLD;
						end
					end
					ACS_DONE: begin
						if (cfg.power_down_idle)
							cell_power <= 1'b0;
						state <= ACS_IDLE;
					end
					default: state <= ACS_IDLE;
				endcase
			end
		end
	end

	assign cell_sample = (state == ACS_HOLD);
	assign cell_start = tick && (state == ACS_HOLD) && (count + 11'h001 >= hold_len);
	assign cell_channel = chan;
	assign touch_active = (state == ACS_HOLD || state == ACS_CONV) && touch_mask[chan];

	always_ff @(posedge clk) begin
		if (rst) begin
			chen <= 8'h00;
			latest_sample_reg <= '0;
			unread <= 1'b0;
			ovr <= 1'b0;
			cmp_low <= 1'b0;
			cmp_high <= 1'b0;
			cmp_in <= 1'b0;
		end else begin
			chen <= (chen | channel_enable_set) & ~channel_enable_clear;
			if (result_now) begin
				latest_sample_reg <= '{channel: chan, data: result};
				unread <= 1'b1;
				ovr <= unread & ~sample_read;
				if (cmp.compare_enable) begin
					cmp_low <= result < cmp.compare_low_limit;
					cmp_high <= result > cmp.compare_high_limit;
					cmp_in <= (result >= cmp.compare_low_limit)
						&& (result <= cmp.compare_high_limit);
				end
			end else if (sample_read)
				unread <= 1'b0;
		end
	end

	always_comb begin
		live_flags_reg = 6'h00;
		live_flags_reg[`ACS_F_NEW] = unread;
		live_flags_reg[`ACS_F_OVR] = ovr;
		live_flags_reg[`ACS_F_LOW] = cmp_low;
		live_flags_reg[`ACS_F_HIGH] = cmp_high;
		live_flags_reg[`ACS_F_IN] = cmp_in;
		live_flags_reg[`ACS_F_READY] = (state == ACS_IDLE) && !pending;
	end

	// Flag set wins over a clear landing in the same cycle; mask beats unmask
	always_ff @(posedge clk) begin
		if (rst) begin
			latched_flags_reg <= 6'h00;
			irq_mask_view <= 6'h00;
		end else begin
			latched_flags_reg <= (latched_flags_reg & ~latched_flag_clear)
				| live_flags_reg;
			irq_mask_view <= (irq_mask_view | irq_unmask_set) & ~irq_mask_set;
		end
	end

	assign irq = |(latched_flags_reg & irq_mask_view);
endmodule

// *** verif/acs_sequencer_properties.sv ***
`timescale 1ns/1ps
`include "acs_defines.svh"
module acs_sequencer_checker
	import acs_pkg::*;
(
	input wire logic       clk,                // Bus clock
	input wire logic       rst,                // Sync reset
	input wire acs_cfg_t   cfg,                // Configuration
	input wire logic [5:0] irq_unmask_set,     // Unmask strobes
	input wire logic [5:0] irq_mask_set,       // Mask strobes
	input wire logic [5:0] latched_flag_clear, // Clear strobes
	input wire logic       cell_power,         // Cell powered
	input wire logic       cell_sample,        // Hold active
	input wire logic [2:0] cell_channel,       // Mux select
	input wire logic [7:0] channel_enable_view, // Active channels
	input wire logic [5:0] live_flags_reg,     // Live status
	input wire logic [5:0] latched_flags_reg,  // Sticky status
	input wire logic [5:0] irq_mask_view,      // Enabled sources
	input wire logic       irq                 // Request
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_irq; irq == |(latched_flags_reg & irq_mask_view); endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
	property p_mask_on; |irq_unmask_set |=> ((irq_mask_view | $past(irq_mask_set))
		& $past(irq_unmask_set)) == $past(irq_unmask_set); endproperty
	a_mask_on: assert property (p_mask_on) else $error("unmask lost");
	property p_mask_off; |irq_mask_set |=> !(|(irq_mask_view & $past(irq_mask_set))); endproperty
	a_mask_off: assert property (p_mask_off) else $error("mask lost");
	property p_sticky; !rst |=> ((latched_flags_reg | $past(latched_flag_clear))
		& $past(latched_flags_reg)) == $past(latched_flags_reg); endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");
	property p_src; !rst |=> (latched_flags_reg & $past(live_flags_reg)) == $past(live_flags_reg);
	endproperty
	a_src: assert property (p_src) else $error("live flag not latched");
	property p_keep; !cfg.power_down_idle && cell_power |=> cell_power; endproperty
	a_keep: assert property (p_keep) else $error("cell powered off");
	property p_ready; live_flags_reg[`ACS_F_READY] |-> !cell_sample; endproperty
	a_ready: assert property (p_ready) else $error("ready while busy");
	property p_on; cell_sample |-> cell_power && channel_enable_view[cell_channel]; endproperty
	a_on: assert property (p_on) else $error("bad sample");
endmodule
bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_inst (.clk, .rst, .cfg,
	.irq_unmask_set, .irq_mask_set, .latched_flag_clear, .cell_power, .cell_sample,
	.cell_channel, .channel_enable_view, .live_flags_reg, .latched_flags_reg, .irq_mask_view, .irq);

// *** verif/acs_analog_model.sv ***
`timescale 1ns/1ps
module acs_analog_model (
	input  wire logic       clk,          // Bus clock
	input  wire logic       cell_power,   // Cell powered
	input  wire logic [2:0] cell_channel, // Selected input
	input  wire logic [9:0] base,         // Level of input 0
	output logic     [11:0] cell_result   // Cell code
);
	logic [11:0] off_pat = 12'ha5a;
	// Unpowered cell toggles, so a stale code never looks valid
	always_ff @(posedge clk) off_pat <= ~off_pat;
	assign cell_result = cell_power ? {2'h0, base + 10'(cell_channel) * 10'h45} : off_pat;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`include "acs_defines.svh"
module tb_top;
	import acs_pkg::*;
	logic        clk = 0, rst = 1, start = 0, peripheral_event = 0, sample_read = 0;
	logic        touch_mode_enable = 0, reading = 1, flush = 0;
	acs_cfg_t    cfg = '0;
	acs_cmp_t    cmp = '0;
	logic [2:0]  trigger_source_select = 0, touch_pin_offset = 0, cell_channel;
	logic [7:0]  channel_enable_set = 0, channel_enable_clear = 0, channel_enable_view;
	logic [5:0]  irq_unmask_set = 0, irq_mask_set = 0, latched_flag_clear = 0;
	logic [5:0]  live_flags_reg, latched_flags_reg, irq_mask_view;
	logic [9:0]  base = 0;
	logic [11:0] cell_result, d;
	logic        cell_power, cell_sample, cell_start, touch_active, irq;
	acs_sample_t latest_sample_reg;
	int          n_fail = 0, check_count = 0, per = 2, cnt = -1, hcnt = 0;
	logic [2:0]  expq[$];
	acs_sequencer acs_sequencer_inst (.clk, .rst, .cfg, .cmp, .trigger_source_select,
		.peripheral_event, .start, .channel_enable_set, .channel_enable_clear, .touch_mode_enable,
		.touch_pin_offset, .irq_unmask_set, .irq_mask_set, .latched_flag_clear, .sample_read,
		.cell_result, .cell_power, .cell_sample, .cell_start, .cell_channel, .touch_active,
		.channel_enable_view, .latest_sample_reg, .live_flags_reg, .latched_flags_reg,
		.irq_mask_view, .irq);
	acs_analog_model acs_analog_model_inst (.clk, .cell_power, .cell_channel, .base, .cell_result);
	task automatic check(input logic [15:0] got, exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever #10 clk = ~clk;
	initial begin
		#1000000;
		n_fail++;
		end_sim;
	end
	// Result lands ten conversion clocks after hold ends
	always @(negedge clk) if (!touch_mode_enable) begin
		// Flush reads away a result left unread by an earlier round
		sample_read <= flush;
		if (cell_sample) hcnt++;
		else if (hcnt > 0) begin
			check(hcnt, (cfg.sample_hold_cycles + 1) * per);
			hcnt = 0;
			cnt = 0;
		end else if (cnt >= 0 && ++cnt == 10 * per) begin
			cnt = -1;
			d = {2'h0, base + 10'(expq[0]) * 10'h45};
			if (cfg.bit_depth_select == `ACS_RES_8)
				d = {4'h0, d[9:2]};
			check(live_flags_reg[`ACS_F_NEW], 1);
			check(latest_sample_reg.channel, expq.pop_front());
			check(latest_sample_reg.data, d);
			check(live_flags_reg[4:2], {d >= cmp.compare_low_limit && d <= cmp.compare_high_limit,
				d > cmp.compare_high_limit, d < cmp.compare_low_limit});
			sample_read <= reading;
		end
	end
	task automatic round(input int i);
		logic [7:0] m;
		int         t;
		m = 8'($urandom) | 8'h1;
		flush = 1'h1;
		cfg = '{(i == 7) ? `ACS_RES_8 : `ACS_RES_10, 6'($urandom % 2), 7'($urandom % 2),
			4'($urandom), i[0]};
		per = 2 * (cfg.clock_divider_select + 1);
		cmp.compare_low_limit = 12'($urandom % 1024);
		cmp.compare_high_limit = cmp.compare_low_limit + 12'($urandom % 512);
		cmp.compare_enable = 1'h1;
		base = 10'($urandom);
		reading = (i != 2);
		touch_mode_enable = (i == 5);
		touch_pin_offset = 3'($urandom % 5);
		channel_enable_set = m;
		channel_enable_clear = ~m;
		latched_flag_clear = 6'h3f;
		irq_unmask_set = 6'($urandom);
		irq_mask_set = 6'($urandom);
		for (int c = 0; c < 8; c++) if (m[c] && i != 5) expq.push_back(3'(c));
		@(negedge clk);
		{channel_enable_set, channel_enable_clear, latched_flag_clear} = '0;
		{irq_unmask_set, irq_mask_set} = '0;
		check(channel_enable_view, i == 5 ? m | 8'(8'hf << touch_pin_offset) : m);
		trigger_source_select = i[1] ? `ACS_TRG_EVENT : `ACS_TRG_OFF;
		if (i[1]) peripheral_event = 1'h1;
		else start = 1'h1;
		@(negedge clk);
		{peripheral_event, start} = '0;
		flush = 1'h0;
		trigger_source_select = `ACS_TRG_OFF;
		for (t = 0; t < 20000 && !live_flags_reg[`ACS_F_READY]; t++) @(negedge clk);
		repeat (3) @(negedge clk);
		check(t < 20000, 1);
		check(expq.size(), 0);
		check(cell_power, !cfg.power_down_idle);
		// Live bit reflects the last write only; latched may carry an older round
		if (i != 5) check(live_flags_reg[`ACS_F_OVR], !reading && $countones(m) > 1);
		touch_mode_enable = 1'h0;
	endtask
	initial begin
		void'($urandom(32'h586c));
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'h0;
		@(negedge clk);
		check({latched_flags_reg, channel_enable_view, cell_power}, 15'h4000);
		for (int i = 0; i < 10; i++) round(i);
		end_sim;
	end
endmodule
